/* src/swc_top.sv */
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/100ps
module swc_top
  import swc_pkg::*;
(
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire swc_core_s       core,
  input  wire logic [NSRC-1:0] irq_flag_pin,
  input  wire logic            master_clear_pin,
  input  wire logic [7:0]      pin_out_in,
  input  wire logic [7:0]      pin_oe_in,
  output logic      [7:0]      pin_out,
  output logic      [7:0]      pin_oe,
  output logic                 osc_drive_en,
  output logic                 core_clk_en,
  output logic                 device_reset,
  output logic                 master_clear_pin_pin_out,
  output logic                 master_clear_pin_pin_oe,
  output logic                 wdt_reset,
  output logic                 prefetch,
  output logic      [15:0]     prefetch_addr,
  output swc_jump_s            jump
);
  swc_state_e       state;
  logic [NSRC-1:0]  flag_s1;
  logic [NSRC-1:0]  flag_s2;
  logic             master_clear_pin_s1;
  logic             master_clear_pin_s2;
  logic [1:0]       ctrl;
  logic [NSRC-1:0]  enable;
  logic [3:0]       mode;
  logic             power_down_flag;
  logic             timeout_flag;
  logic [WDT_W-1:0] wdt_cnt;
  logic             wake_req;
  logic             wdt_expire;
  logic             sleep_go;
  logic             wr_en;
  logic             rd_en;

  // pin inputs through two flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_s1 <= '0;
      flag_s2 <= '0;
      master_clear_pin_s1 <= 1'b1;
      master_clear_pin_s2 <= 1'b1;
    end else begin
      flag_s1 <= irq_flag_pin;
      flag_s2 <= flag_s1;
      master_clear_pin_s1 <= master_clear_pin;
      master_clear_pin_s2 <= master_clear_pin_s1;
    end
  end

  swc_wake_gate swc_wake_gate_inst (
    .flag     (flag_s2),
    .enable   (enable),
    .mode     (mode),
    .wake_req (wake_req)
  );

  // APB slave, zero wait
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_ENABLE) || (a == ADDR_MODE);
  endfunction : mapped

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl   <= RST_CTRL;
      enable <= RST_ENABLE;
      mode   <= RST_MODE;
    end else if (wr_en) begin
      if (paddr == ADDR_CTRL) begin
        ctrl <= pwdata[1:0];
      end
      if (paddr == ADDR_ENABLE) begin
        enable <= pwdata[NSRC-1:0];
      end
      if (paddr == ADDR_MODE) begin
        mode <= pwdata[3:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped(paddr);
      prdata  <= 32'h0;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          ADDR_CTRL:   prdata <= {30'h0, ctrl};
          ADDR_STATUS: prdata <= {29'h0, state == SWC_SLEEP, timeout_flag, power_down_flag};
          ADDR_ENABLE: prdata <= {24'h0, enable};
          ADDR_MODE:   prdata <= {28'h0, mode};
          default:     prdata <= 32'h0;
        endcase
      end
    end
  end

  // sleep only via the instruction strobe
  assign sleep_go   = (state == SWC_RUN) && core.sleep_exec;
  assign wdt_expire = ctrl[CTRL_WDTEN] && (wdt_cnt == WDT_LIMIT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= SWC_RUN;
    end else if (!master_clear_pin_s2) begin
      state <= SWC_RUN;
    end else begin
      unique case (state)
        SWC_RUN:    if (sleep_go) state <= SWC_SLEEP;
        // pending request still completes entry, then leaves next cycle
        SWC_SLEEP:  if (wake_req || wdt_expire) state <= SWC_RESUME;
        SWC_RESUME: state <= SWC_RUN;
      endcase
    end
  end

  // watchdog counts in sleep too; cleared on entry and on wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_cnt <= '0;
    end else if (!ctrl[CTRL_WDTEN] || sleep_go || state == SWC_RESUME || wdt_expire) begin
      wdt_cnt <= '0;
    end else begin
      wdt_cnt <= wdt_cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_down_flag <= 1'b1;
      timeout_flag    <= 1'b1;
    end else if (!master_clear_pin_s2) begin
      power_down_flag <= 1'b1;
      timeout_flag    <= 1'b1;
    end else if (sleep_go) begin
      power_down_flag <= 1'b0;
      timeout_flag    <= 1'b1;
    end else if (state == SWC_SLEEP && wdt_expire) begin
      timeout_flag    <= 1'b0;
    end
  end

  // wake / reset outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      device_reset <= 1'b1;
      wdt_reset    <= 1'b0;
      master_clear_pin_pin_out <= 1'b0;
      master_clear_pin_pin_oe  <= 1'b0;
    end else begin
      device_reset <= !master_clear_pin_s2;
      wdt_reset    <= (state == SWC_RUN) && wdt_expire;
      master_clear_pin_pin_out <= 1'b0;
      master_clear_pin_pin_oe  <= 1'b0;
    end
  end

  // oscillator and core clock gating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_drive_en <= 1'b1;
      core_clk_en  <= 1'b1;
    end else begin
      osc_drive_en <= !(sleep_go || (state == SWC_SLEEP && !(wake_req || wdt_expire)));
      core_clk_en  <= !(sleep_go || (state == SWC_SLEEP && !(wake_req || wdt_expire)));
    end
  end

  // pins frozen during sleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= 8'h00;
      pin_oe  <= 8'h00;
    end else if (state == SWC_RUN && !sleep_go) begin
      pin_out <= pin_out_in;
      pin_oe  <= pin_oe_in;
    end else if (state == SWC_RESUME) begin
      pin_out <= pin_out_in;
      pin_oe  <= pin_oe_in;
    end
  end

  // prefetch next, then vector after it when an enabled source wakes it with global enable set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prefetch      <= 1'b0;
      prefetch_addr <= 16'h0000;
      jump          <= '0;
    end else begin
      prefetch <= sleep_go;
      if (sleep_go) begin
        prefetch_addr <= core.pc + 16'h0001;
      end
      jump.redirect <= (state == SWC_RESUME) && wake_req && ctrl[CTRL_GIE];
      jump.target   <= IRQ_VECTOR;
    end
  end

  AST_SLEEP_CLEARS_PD: assert property (@(posedge pclk) disable iff (!presetn)
    sleep_go && master_clear_pin_s2 |=> !power_down_flag && timeout_flag)
    else $error("sleep entry did not update status flags");
  AST_ONLY_INSTR: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state == SWC_SLEEP) |-> $past(core.sleep_exec))
    else $error("sleep entered without instruction");
  AST_WDT_CLEARED: assert property (@(posedge pclk) disable iff (!presetn)
    sleep_go |=> wdt_cnt == '0)
    else $error("watchdog not cleared on sleep");
  AST_OSC_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    sleep_go |=> !osc_drive_en)
    else $error("oscillator still driven in sleep");
  AST_PINS_HELD: assert property (@(posedge pclk) disable iff (!presetn)
    state == SWC_SLEEP && $past(state == SWC_SLEEP) |-> $stable(pin_out) && $stable(pin_oe))
    else $error("pins changed in sleep");
  AST_NO_MASTER_CLEAR_PIN_DRIVE: assert property (@(posedge pclk) disable iff (!presetn)
    !master_clear_pin_pin_oe)
    else $error("master clear driven");
  AST_WAKE_FAST: assert property (@(posedge pclk) disable iff (!presetn)
    state == SWC_SLEEP && wake_req && master_clear_pin_s2 |=> state == SWC_RESUME ##1 state == SWC_RUN)
    else $error("wake did not follow pending request");
  AST_WDT_WAKE_TO: assert property (@(posedge pclk) disable iff (!presetn)
    state == SWC_SLEEP && wdt_expire && master_clear_pin_s2 |=> !timeout_flag)
    else $error("timeout flag not cleared on watchdog wake");
  AST_VECTOR: assert property (@(posedge pclk) disable iff (!presetn)
    state == SWC_RESUME && wake_req && !ctrl[CTRL_GIE] |=> !jump.redirect)
    else $error("vectored with global enable clear");
  AST_PREFETCH: assert property (@(posedge pclk) disable iff (!presetn)
    sleep_go |=> prefetch && prefetch_addr == $past(core.pc) + 16'h0001)
    else $error("prefetch address wrong");
endmodule : swc_top

/* src/swc_pkg.sv */
package swc_pkg;
  // wake source indices
  localparam int SRC_TMR1  = 0;
  localparam int SRC_RX    = 1;
  localparam int SRC_ADC   = 2;
  localparam int SRC_IOC   = 3;
  localparam int SRC_EXT   = 4;
  localparam int SRC_CAPA  = 5;
  localparam int SRC_CAPB  = 6;
  localparam int SRC_SSP   = 7;
  localparam int NSRC      = 8;

  // register byte addresses
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_ENABLE = 12'h008;
  localparam logic [11:0] ADDR_MODE   = 12'h00C;

  // ctrl fields
  localparam int CTRL_GIE   = 0;
  localparam int CTRL_WDTEN = 1;
  // status fields
  localparam int ST_PD      = 0;
  localparam int ST_TO      = 1;
  localparam int ST_ASLEEP  = 2;
  // mode fields
  localparam int MODE_T1ASYNC = 0;
  localparam int MODE_RXSLAVE = 1;
  localparam int MODE_ADC_RC  = 2;
  localparam int MODE_SSPSLV  = 3;

  localparam logic [15:0] IRQ_VECTOR   = 16'h0004;
  localparam logic [7:0]  RST_ENABLE   = 8'h00;
  localparam logic [3:0]  RST_MODE     = 4'h0;
  localparam logic [1:0]  RST_CTRL     = 2'h0;
  localparam int          WDT_W        = 16;
  localparam logic [15:0] WDT_LIMIT    = 16'hFFFF;

  typedef enum logic [1:0] {
    SWC_RUN,
    SWC_SLEEP,
    SWC_RESUME
  } swc_state_e;

  typedef struct packed {
    logic        sleep_exec;
    logic [15:0] pc;
  } swc_core_s;

  typedef struct packed {
    logic        redirect;
    logic [15:0] target;
  } swc_jump_s;
endpackage : swc_pkg

/* src/swc_wake_gate.sv */
`timescale 1ns/100ps
module swc_wake_gate
  import swc_pkg::*;
(
  input  wire logic [NSRC-1:0] flag,
  input  wire logic [NSRC-1:0] enable,
  input  wire logic [3:0]      mode,
  output logic                 wake_req
);
  logic [NSRC-1:0] capable;

  always_comb begin
    capable           = '1;
    capable[SRC_TMR1] = mode[MODE_T1ASYNC];
    capable[SRC_RX]   = mode[MODE_RXSLAVE];
    capable[SRC_ADC]  = mode[MODE_ADC_RC];
    capable[SRC_SSP]  = mode[MODE_SSPSLV];
  end

  // ioc, ext and captures always capable; global enable not involved
  assign wake_req = |(flag & enable & capable);
endmodule : swc_wake_gate

/* bench/swc_src_model.sv */
`timescale 1ns/100ps
module swc_src_model
  import swc_pkg::*;
(
  input  wire logic            pclk,
  input  wire logic [NSRC-1:0] req,
  input  wire logic            slow,
  input  wire logic            master_clear_pin_req,
  output logic      [NSRC-1:0] irq_flag_pin,
  output logic                 master_clear_pin
);
  logic [NSRC-1:0] d1;
  logic [NSRC-1:0] d2;
  // every source has a line; slow adds a second cycle of delay
  always_ff @(posedge pclk) begin
    d1 <= req;
    d2 <= d1;
  end
  assign irq_flag_pin = slow ? d2 : d1;
  // pin pulled high unless held low
  always_ff @(posedge pclk) begin
    master_clear_pin <= ~master_clear_pin_req;
  end
endmodule : swc_src_model

/* bench/tb_sleep_wake_control.sv */
`timescale 1ns/100ps
module tb_sleep_wake_control;
  import swc_pkg::*;
  logic            pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0]     paddr = '0;
  logic [31:0]     pwdata = '0, prdata, r;
  logic            pready, pslverr, last_err, slow = 0, master_clear_pin_req = 0, g, c;
  swc_core_s       core = '0;
  logic [7:0]      pin_out_in = '0, pin_oe_in = '0, pin_out, pin_oe, pv;
  logic [NSRC-1:0] req = '0, irq_flag_pin;
  logic            master_clear_pin, osc_drive_en, core_clk_en, device_reset;
  logic            master_clear_pin_pin_out, master_clear_pin_pin_oe, wdt_reset, prefetch;
  logic [15:0]     prefetch_addr, pf_addr, pc;
  logic [3:0]      m;
  swc_jump_s       jump;
  int              err_total = 0, check_count = 0, nredir = 0, n0;
  int              seed = 32'hcc8a;
  logic [31:0]     exp_q[$];

  swc_top swc_top_inst (.*);
  swc_src_model swc_src_model_inst (.*);

  always #50 pclk = ~pclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  always @(negedge pclk) begin
    if (prefetch) begin
      pf_addr = prefetch_addr;
    end
    if (jump.redirect) begin
      nredir++;
      chk({16'h0, jump.target}, {16'h0, IRQ_VECTOR});
    end
    if (psel && penable && pready && !pwrite) begin
      chk(prdata, exp_q.pop_front());
    end
    chk({31'h0, master_clear_pin_pin_oe}, 32'h0);
    chk({31'h0, master_clear_pin_pin_out}, 32'h0);
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (!pready && n < 50);
    if (!pready) chk(0, 1);
    last_err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(0, a, 0);
  endtask : rd

  task automatic slp();
    r = $random(seed);
    pc = r[15:0];
    pin_out_in <= r[23:16];
    pin_oe_in <= r[31:24];
    @(posedge pclk);
    pv = pin_out_in;
    core <= '{1'b1, pc};
    @(posedge pclk);
    core.sleep_exec <= 0;
    @(posedge pclk);
    pin_out_in <= ~pv;
    chk({16'h0, pf_addr}, {16'h0, pc + 16'h1});
  endtask : slp

  function automatic logic cap(input int i, input logic [3:0] mm);
    case (i)
      SRC_TMR1: return mm[MODE_T1ASYNC];
      SRC_RX:   return mm[MODE_RXSLAVE];
      SRC_ADC:  return mm[MODE_ADC_RC];
      SRC_SSP:  return mm[MODE_SSPSLV];
      default:  return 1'b1;
    endcase
  endfunction : cap

  initial begin
    #9000000;
    err_total++;
    wrap_up();
  end

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rd(ADDR_STATUS, 32'h3);
    apb(1, 12'h010, 32'hFF);
    chk({31'h0, last_err}, 32'h1);
    apb(1, ADDR_MODE, 32'hF);
    slp();
    req <= 8'hFF;
    repeat (8) @(posedge pclk);
    rd(ADDR_STATUS, 32'h6);
    chk({31'h0, osc_drive_en}, 32'h0);
    chk({31'h0, core_clk_en}, 32'h0);
    chk({24'h0, pin_out}, {24'h0, pv});
    apb(1, ADDR_ENABLE, 32'hFF);
    repeat (8) @(posedge pclk);
    rd(ADDR_STATUS, 32'h2);
    slp();
    repeat (8) @(posedge pclk);
    rd(ADDR_STATUS, 32'h2);
    req <= 0;
    for (int i = 0; i < NSRC; i++) begin
      r = $random(seed);
      m = r[3:0];
      g = r[4];
      slow <= r[5];
      apb(1, ADDR_ENABLE, 32'h1 << i);
      apb(1, ADDR_MODE, {28'h0, m});
      apb(1, ADDR_CTRL, {31'h0, g});
      n0 = nredir;
      slp();
      c = cap(i, m);
      req <= 8'h1 << i;
      repeat (8) @(posedge pclk);
      rd(ADDR_STATUS, {29'h0, ~c, 2'b10});
      apb(1, ADDR_MODE, 32'hF);
      repeat (8) @(posedge pclk);
      chk(nredir - n0, {31'h0, g});
      req <= 0;
      repeat (4) @(posedge pclk);
    end
    apb(1, ADDR_ENABLE, 32'h0);
    apb(1, ADDR_CTRL, 32'h2);
    repeat (10000) @(posedge pclk);
    slp();
    repeat (58000) @(posedge pclk);
    rd(ADDR_STATUS, 32'h6);
    repeat (8000) @(posedge pclk);
    rd(ADDR_STATUS, 32'h0);
    slp();
    master_clear_pin_req <= 1;
    repeat (6) @(posedge pclk);
    chk({31'h0, device_reset}, 32'h1);
    master_clear_pin_req <= 0;
    repeat (6) @(posedge pclk);
    rd(ADDR_STATUS, 32'h3);
    wrap_up();
  end
endmodule : tb_sleep_wake_control
